// >>> logic/pin_io_map.svh
// register map, field positions, reset values and timing counts for the pin io block
// Summary of operation
// - each path combinational or flip-flop, by configuration
// - double data rate on every path
// - up to 256 delay taps of 100 ps
// - one delay follows pin direction automatically
// - tap loaded at start, then inc/dec
// - system-synchronous mode inserts zero-hold tap automatically
// - measure io period in taps, load half
// - phase detector only on differential inputs
// - phase detector steps delay one tap
// - deserializer word width 2, 3 or 4
// - differential pair cascades to 5..8 bits
// - serializer word width 2, 3 or 4
// - differential driver cascades to 5..8 bits
// - shift at single rate on doubled clock
// - doubling by pll or both io edges
// - io clock feeds only delay and shifters
`ifndef PIN_IO_MAP_SVH
`define PIN_IO_MAP_SVH
`define OFS_CTRL        12'h000
`define OFS_TAP         12'h004
`define OFS_STATUS      12'h008
`define OFS_RXDATA      12'h00c
`define CTRL_IN_REG     0
`define CTRL_OUT_REG    1
`define CTRL_DDR        2
`define CTRL_DIFF       3
`define CTRL_WIDTH_LSB  4
`define CTRL_WIDTH_MSB  7
`define CTRL_DIR_OUT    8
`define CTRL_MODE_LSB   9
`define CTRL_MODE_MSB   10
`define CTRL_CAL_START  11
`define CTRL_RESET      32'h0000_0020
`define TAP_RESET       8'h00
`define TAP_MAX         8'hff
`define ZERO_HOLD_TAP   8'h10
`define STAT_BUSY       8
`define STAT_TX_BUSY    9
`define STAT_MEAS_LSB   16
`define TAP_STEP_PS     100
`define PCLK_PERIOD_PS  25000
`define TAPS_PER_PCLK   (`PCLK_PERIOD_PS / `TAP_STEP_PS)
`define WIDTH_MIN       4'h2
`define WIDTH_SINGLE    4'h4
`define WIDTH_PAIR      4'h8
`endif

// >>> logic/pin_io_pkg.sv
// types shared by the pin io block
package pin_io_pkg;
  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_ARM  = 4'b0010,
    CAL_MEAS = 4'b0100,
    CAL_LOAD = 4'b1000
  } cal_state_t;
  typedef enum logic [1:0] {
    MODE_OFF       = 2'b00,
    MODE_ZERO_HOLD = 2'b01,
    MODE_CENTRE    = 2'b10,
    MODE_PHASE     = 2'b11
  } cal_mode_t;
  typedef logic [7:0] tap_t;
endpackage

// >>> logic/pin_io_block.sv
// pin io block: tap delay control, calibration, deserializer, serializer, apb registers
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "pin_io_map.svh"
module pin_io_block (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              io_clk_in,
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe_n,
  output logic      [7:0]        rx_word,
  output logic                   rx_valid,
  input  wire logic [7:0]        tx_word,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic              tap_inc,
  input  wire logic              tap_dec,
  output logic                   tap_ack,
  output pin_io_pkg::tap_t       tap_setting,
  output logic                   tap_on_output
);
  import pin_io_pkg::*;

  // ----------------------------------------------------------------
  // pin and link clock synchronisers
  // ----------------------------------------------------------------
  logic [1:0] clk_s_q, pin_s_q;
  logic       clk_old_q, in_q;
  logic       io_rise, io_fall, bit_edge;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s_q   <= 2'b00;
      pin_s_q   <= 2'b00;
      clk_old_q <= 1'b0;
      in_q      <= 1'b0;
    end else begin
      clk_s_q   <= {clk_s_q[0], io_clk_in};
      pin_s_q   <= {pin_s_q[0], pin_in};
      clk_old_q <= clk_s_q[1];
      in_q      <= pin_s_q[1];
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  tap_t        tapcfg_q, tapcfg_d;
  logic        wr, rd_hit;
  logic        cal_start, zero_hold_wr, tapcfg_wr;
  logic [3:0]  width_req, width;
  logic        in_reg, out_reg, ddr, diff;
  cal_mode_t   mode;

  assign wr           = psel && penable && pwrite;
  assign pready       = 1'b1;
  assign cal_start    = wr && paddr == `OFS_CTRL && pwdata[`CTRL_CAL_START];
  assign zero_hold_wr = wr && paddr == `OFS_CTRL
                        && pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == MODE_ZERO_HOLD;
  assign tapcfg_wr    = wr && paddr == `OFS_TAP;
  assign in_reg       = ctrl_q[`CTRL_IN_REG];
  assign out_reg      = ctrl_q[`CTRL_OUT_REG];
  assign ddr          = ctrl_q[`CTRL_DDR];
  assign diff         = ctrl_q[`CTRL_DIFF];
  assign mode         = cal_mode_t'(ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
  assign width_req    = ctrl_q[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];

  // io edges only pace the delay and shift logic
  assign io_rise  = clk_s_q[1] && !clk_old_q;
  assign io_fall  = !clk_s_q[1] && clk_old_q;
  // both edges of a double-rate clock give a doubled single-rate shift; a pll-doubled clock
  // uses its rising edge only
  assign bit_edge = io_rise || (ddr && io_fall);

  // widths above four need the partner pin of a differential pair
  always_comb begin
    width = width_req;
    if (width_req < `WIDTH_MIN) begin
      width = `WIDTH_MIN;
    end else if (!diff && width_req > `WIDTH_SINGLE) begin
      width = `WIDTH_SINGLE;
    end else if (width_req > `WIDTH_PAIR) begin
      width = `WIDTH_PAIR;
    end
  end

  always_comb begin
    ctrl_d   = ctrl_q;
    tapcfg_d = tapcfg_q;
    if (wr && paddr == `OFS_CTRL) begin
      ctrl_d = pwdata & ~(32'h0000_0001 << `CTRL_CAL_START);
    end
    if (tapcfg_wr) begin
      tapcfg_d = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `CTRL_RESET;
      tapcfg_q <= `TAP_RESET;
    end else begin
      ctrl_q   <= ctrl_d;
      tapcfg_q <= tapcfg_d;
    end
  end

  // ----------------------------------------------------------------
  // tap counter, calibration and phase detector
  // ----------------------------------------------------------------
  cal_state_t  cal_q, cal_d;
  tap_t        tap_q, tap_d;
  logic [7:0]  meas_q, meas_d;
  logic        prev_q, prev_d, mid_q, mid_d, ack_d, ack_q;
  logic        step_up, step_dn, pd_up, pd_dn, pd_on;
  logic [15:0] period_taps;
  tap_t        half_tap;

  // period in taps saturates at the longest delay before halving
  assign period_taps = {8'h00, meas_q} * 16'(`TAPS_PER_PCLK);
  assign half_tap    = (period_taps > {8'h00, `TAP_MAX}) ? (`TAP_MAX >> 1)
                       : tap_t'(period_taps[7:0] >> 1);
  assign pd_on       = diff && mode == MODE_PHASE;
  // a data change between the last two bits with the mid sample already at the new value
  // means sampling is late; still at the old value means early
  assign pd_up       = pd_on && io_rise && prev_q != in_q && mid_q == prev_q;
  assign pd_dn       = pd_on && io_rise && prev_q != in_q && mid_q == in_q;
  assign step_up     = pd_up || (!pd_on && tap_inc && !ack_q);
  assign step_dn     = pd_dn || (!pd_on && tap_dec && !tap_inc && !ack_q);

  always_comb begin
    cal_d  = cal_q;
    tap_d  = tap_q;
    meas_d = meas_q;
    prev_d = io_rise ? in_q : prev_q;
    mid_d  = io_fall ? in_q : mid_q;
    ack_d  = 1'b0;
    unique case (cal_q)
      CAL_IDLE: begin
        if (cal_start && ctrl_d[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == MODE_CENTRE) begin
          cal_d = CAL_ARM;
        end
      end
      CAL_ARM: begin
        meas_d = 8'h00;
        if (io_rise) begin
          cal_d = CAL_MEAS;
        end
      end
      CAL_MEAS: begin
        if (meas_q != 8'hff) begin
          meas_d = meas_q + 8'h01;
        end
        if (io_rise) begin
          cal_d = CAL_LOAD;
        end
      end
      CAL_LOAD: begin
        cal_d = CAL_IDLE;
      end
    endcase
    if (cal_q == CAL_LOAD) begin
      tap_d = half_tap;
    end else if (zero_hold_wr) begin
      tap_d = `ZERO_HOLD_TAP;
    end else if (tapcfg_wr) begin
      tap_d = pwdata[7:0];
    end else if (step_up) begin
      tap_d = (tap_q == `TAP_MAX) ? tap_q : tap_q + 8'h01;
      ack_d = !pd_on;
    end else if (step_dn) begin
      tap_d = (tap_q == 8'h00) ? tap_q : tap_q - 8'h01;
      ack_d = !pd_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q  <= CAL_IDLE;
      tap_q  <= `TAP_RESET;
      meas_q <= 8'h00;
      prev_q <= 1'b0;
      mid_q  <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      cal_q  <= cal_d;
      tap_q  <= tap_d;
      meas_q <= meas_d;
      prev_q <= prev_d;
      mid_q  <= mid_d;
      ack_q  <= ack_d;
    end
  end

  // the single delay follows the pin's current direction
  assign tap_setting   = tap_q;
  assign tap_on_output = ctrl_q[`CTRL_DIR_OUT];
  assign tap_ack       = ack_q;

  // ----------------------------------------------------------------
  // deserializer
  // ----------------------------------------------------------------
  logic [7:0] sh_q, sh_d, rxw_q, rxw_d, mask, sh_next;
  logic [3:0] rcnt_q, rcnt_d;
  logic       rxv_q, rxv_d, cap_bit;

  // combinational capture skips the extra flip-flop
  assign cap_bit = in_reg ? in_q : pin_s_q[1];
  assign sh_next = {sh_q[6:0], cap_bit};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign mask[gi] = 4'(gi) < width;
    end
  endgenerate

  always_comb begin
    sh_d   = sh_q;
    rcnt_d = rcnt_q;
    rxw_d  = rxw_q;
    rxv_d  = 1'b0;
    if (!ctrl_q[`CTRL_DIR_OUT] && bit_edge) begin
      sh_d = sh_next;
      if (rcnt_q + 4'h1 >= width) begin
        rcnt_d = 4'h0;
        rxw_d  = sh_next & mask;
        rxv_d  = 1'b1;
      end else begin
        rcnt_d = rcnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q   <= 8'h00;
      rcnt_q <= 4'h0;
      rxw_q  <= 8'h00;
      rxv_q  <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      rcnt_q <= rcnt_d;
      rxw_q  <= rxw_d;
      rxv_q  <= rxv_d;
    end
  end

  assign rx_word  = rxw_q;
  assign rx_valid = rxv_q;

  // ----------------------------------------------------------------
  // serializer
  // ----------------------------------------------------------------
  logic [7:0] tsh_q, tsh_d;
  logic [3:0] left_q, left_d;
  logic       out_q, out_d;

  assign tx_ready = ctrl_q[`CTRL_DIR_OUT] && left_q == 4'h0;

  always_comb begin
    tsh_d  = tsh_q;
    left_d = left_q;
    out_d  = out_q;
    if (tx_valid && tx_ready) begin
      tsh_d  = tx_word & mask;
      left_d = width;
    end else if (bit_edge && left_q != 4'h0) begin
      out_d  = tsh_q[0];
      tsh_d  = {1'b0, tsh_q[7:1]};
      left_d = left_q - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsh_q  <= 8'h00;
      left_q <= 4'h0;
      out_q  <= 1'b0;
    end else begin
      tsh_q  <= tsh_d;
      left_q <= left_d;
      out_q  <= out_d;
    end
  end

  // combinational launch shows the bit in shift as soon as it is loaded
  assign pin_out  = out_reg ? out_q : (left_q != 4'h0 && tsh_q[0]);
  assign pin_oe_n = !ctrl_q[`CTRL_DIR_OUT];

  // ----------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `OFS_CTRL:   prdata = ctrl_q;
      `OFS_TAP:    prdata = {24'h00_0000, tapcfg_q};
      `OFS_STATUS: begin
        prdata[7:0]                      = tap_q;
        prdata[`STAT_BUSY]               = cal_q != CAL_IDLE;
        prdata[`STAT_TX_BUSY]            = left_q != 4'h0;
        prdata[`STAT_MEAS_LSB+7:`STAT_MEAS_LSB] = meas_q;
      end
      `OFS_RXDATA: prdata = {24'h00_0000, rxw_q};
      default:     rd_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !rd_hit;

endmodule

// >>> test/pin_io_block_assertions.sv
// port assertions for the pin io block
`timescale 1ns/100ps
module pin_io_block_assertions (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             tap_inc,
  input wire logic             tap_dec,
  input wire logic             tap_ack,
  input wire pin_io_pkg::tap_t tap_setting,
  input wire logic             tap_on_output,
  input wire logic             pin_oe_n,
  input wire logic             rx_valid,
  input wire logic             tx_valid,
  input wire logic             tx_ready
);
  import pin_io_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // step, direction and word checks
  // ----------------------------------------
  property p_ack_one; tap_ack |=> !tap_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_src; $rose(tap_ack) |-> $past(tap_inc || tap_dec); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack uncaused");
  property p_inc; $rose(tap_ack) && $past(tap_inc) && !$past(psel) |->
    tap_setting == ($past(tap_setting) == 8'hff ? 8'hff : $past(tap_setting) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("bad inc");
  property p_dec; $rose(tap_ack) && $past(tap_dec && !tap_inc) && !$past(psel) |->
    tap_setting == ($past(tap_setting) == 8'h00 ? 8'h00 : $past(tap_setting) - 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("bad dec");
  property p_dir; tap_on_output == !pin_oe_n; endproperty
  a_dir: assert property (p_dir) else $error("delay side wrong");
  property p_rdy; tx_ready |-> !pin_oe_n; endproperty
  a_rdy: assert property (p_rdy) else $error("ready while input");
  property p_take; tx_valid && tx_ready |=> !tx_ready; endproperty
  a_take: assert property (p_take) else $error("ready after take");
  property p_rx_one; rx_valid |=> !rx_valid; endproperty
  a_rx_one: assert property (p_rx_one) else $error("valid too long");
  property p_rx_off; !pin_oe_n [*4] |-> !rx_valid; endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx while output");
endmodule

// >>> test/link_peer_model.sv
// peer chip: link clock and serial bits in frames, samples the block output in single-rate frames only
`timescale 1ns/100ps
module link_peer_model (
  input  wire logic       go,
  input  wire logic [7:0] bits,
  input  wire logic [3:0] nbits,
  input  wire logic       ddr,
  input  wire logic       pin_out,
  output logic            io_clk,
  output logic            pin,
  output logic [7:0]      rx_bits,
  output logic            busy
);
  initial begin
    io_clk = 1'b0;
    pin = 1'b1;
    rx_bits = 8'h00;
    busy = 1'b0;
    forever begin
      @(posedge go);
      #1;
      busy = 1'b1;
      for (int i = 0; i < nbits; i++) begin
        pin = bits[nbits - 1 - i];
        #50;
        io_clk = ~io_clk;
        if (!ddr) begin
          #100;
          rx_bits[i] = pin_out;
          io_clk = 1'b0;
        end
        #50;
      end
      // released line flips, clock stands still between frames
      pin = ~pin;
      io_clk = 1'b0;
      #200;
      busy = 1'b0;
    end
  end
endmodule

// >>> test/tb_pin_io_block.sv
// self-checking bench for the pin io block
`timescale 1ns/100ps
`include "pin_io_map.svh"
module tb_pin_io_block;
  import pin_io_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        io_clk_in, pin_in, pin_out, pin_oe_n, rx_valid, tx_valid, tx_ready;
  logic        tap_inc, tap_dec, tap_ack, tap_on_output, go, m_ddr, m_busy;
  logic [7:0]  rx_word, tx_word, rx_got, m_bits, m_rx;
  logic [3:0]  m_n;
  tap_t        tap_setting;
  int          rx_cnt, cyc, err_total, checks;
  pin_io_block i_pin_io_block (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_clk_in(io_clk_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .rx_word(rx_word), .rx_valid(rx_valid), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tap_inc(tap_inc), .tap_dec(tap_dec), .tap_ack(tap_ack),
    .tap_setting(tap_setting), .tap_on_output(tap_on_output));
  link_peer_model i_link_peer_model (.go(go), .bits(m_bits), .nbits(m_n), .ddr(m_ddr),
    .pin_out(pin_out), .io_clk(io_clk_in), .pin(pin_in), .rx_bits(m_rx), .busy(m_busy));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  always @(negedge pclk) begin
    if (rx_valid === 1'b1) begin
      rx_got = rx_word;
      rx_cnt++;
    end
  end
  // ----------------------------------------
  // bus and link tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] b, input logic [3:0] n, input logic dd);
    @(posedge pclk);
    m_bits <= b;
    m_n <= n;
    m_ddr <= dd;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (m_busy === 1'b1);
  endtask
  task automatic rx_one(input logic [31:0] c, input logic [7:0] b, input logic [3:0] n,
                        input logic dd);
    int k;
    apb(`OFS_CTRL, 1'b1, c);
    k = rx_cnt;
    frame(b, n, dd);
    chk(rx_cnt, k + 1);
    chk(rx_got, b & (8'hff >> (8 - n)));
  endtask
  task automatic tx_one(input logic [7:0] w, input logic [3:0] n, input logic [7:0] e);
    @(posedge pclk);
    tx_word <= w;
    tx_valid <= 1'b1;
    do @(posedge pclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    frame(8'h00, n, 1'b0);
    chk(m_rx & (8'hff >> (8 - n)), e & (8'hff >> (8 - n)));
  endtask
  task automatic step(input logic up);
    @(posedge pclk);
    tap_inc <= up;
    tap_dec <= !up;
    do @(negedge pclk); while (tap_ack !== 1'b1);
    @(posedge pclk);
    tap_inc <= 1'b0;
    tap_dec <= 1'b0;
  endtask
  task automatic t_reset;
    chk(tap_setting, `TAP_RESET);
    chk(pin_oe_n, 1'b1);
    apb(`OFS_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, `CTRL_RESET);
    apb(12'h010, 1'b1, 32'h0000_ffff);
    chk(perr, 1'b1);
  endtask
  task automatic t_rx;
    for (int r = 0; r < 2; r++) begin
      for (int w = 2; w < 5; w++) begin
        rx_one(32'(w << 4) | 32'(r), 8'h96 >> r, 4'(w), 1'b0);
      end
    end
    rx_one(32'h0000_0044, 8'h09, 4'h4, 1'b1);
    rx_one(32'h0000_0088, 8'hc6, 4'h8, 1'b0);
  endtask
  task automatic t_tx;
    apb(`OFS_CTRL, 1'b1, 32'h0000_0142);
    @(negedge pclk);
    chk(tap_on_output, 1'b1);
    tx_one(8'h0b, 4'h4, 8'h0b);
    apb(`OFS_CTRL, 1'b1, 32'h0000_018a);
    tx_one(8'hb4, 4'h8, 8'hb4);
    // combinational launch leads each bit by one link edge, so the peer sees it shifted
    apb(`OFS_CTRL, 1'b1, 32'h0000_0140);
    tx_one(8'h05, 4'h4, 8'h02);
  endtask
  task automatic t_tap;
    apb(`OFS_TAP, 1'b1, 32'h0000_00fe);
    step(1'b1);
    chk(tap_setting, 8'hff);
    step(1'b1);
    chk(tap_setting, 8'hff);
    apb(`OFS_TAP, 1'b1, 32'h0000_0001);
    step(1'b0);
    chk(tap_setting, 8'h00);
    step(1'b0);
    chk(tap_setting, 8'h00);
  endtask
  task automatic t_cal;
    apb(`OFS_CTRL, 1'b1, 32'h0000_0220);
    repeat (2) @(negedge pclk);
    chk(tap_setting, `ZERO_HOLD_TAP);
    apb(`OFS_CTRL, 1'b1, 32'h0000_0c20);
    frame(8'h02, 4'h2, 1'b0);
    do apb(`OFS_STATUS, 1'b0, 32'h0000_0000); while (rd[8] !== 1'b0);
    // measured period is far beyond the tap range, so half the ceiling
    chk(tap_setting, 8'hff >> 1);
    // link period of 200 ns over a pclk period of 25 ns
    chk(rd[23:16], 8'h08);
  endtask
  task automatic t_phase;
    apb(`OFS_TAP, 1'b1, 32'h0000_0040);
    apb(`OFS_CTRL, 1'b1, 32'h0000_0620);
    frame(8'h02, 4'h2, 1'b0);
    chk(tap_setting, 8'h40);
    // peer changes data before its rising edge, mid sample still old: one step up per change
    apb(`OFS_CTRL, 1'b1, 32'h0000_0628);
    frame(8'h02, 4'h2, 1'b0);
    chk(tap_setting, 8'h42);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata, tx_word, tx_valid} = '0;
    {tap_inc, tap_dec, go, m_ddr, m_bits, m_n} = '0;
    {rx_cnt, cyc, err_total, checks} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_tx();
    t_tap();
    t_cal();
    t_phase();
    end_of_test();
  end
endmodule
bind pin_io_block pin_io_block_assertions i_pin_io_block_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .tap_inc(tap_inc), .tap_dec(tap_dec),
  .tap_ack(tap_ack), .tap_setting(tap_setting), .tap_on_output(tap_on_output),
  .pin_oe_n(pin_oe_n), .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_ready(tx_ready));
